/* mvp_pkg.sv */
// shared constants, types and helpers for the meter value processing block
package mvp_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SRC = 8'h04;
	localparam logic [7:0] REG_ZERO = 8'h08;
	localparam logic [7:0] REG_FULL = 8'h0C;
	localparam logic [7:0] REG_MARGIN = 8'h10;
	localparam logic [7:0] REG_PEAK = 8'h14;
	localparam logic [7:0] REG_MODBUS = 8'h18;
	localparam logic [7:0] REG_RELAY = 8'h1C;
	localparam logic [7:0] REG_STATUS = 8'h20;

	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_POLICY = 2;
	localparam int CTRL_UNLOCK = 3;
	localparam int CTRL_SHOWN_LSB = 4;
	localparam int CTRL_OUT_PEAK = 6;

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [7:0] SRC_RST = 8'hE4;
	localparam logic signed [15:0] ZERO_RST = 16'sh0000;
	localparam logic signed [15:0] FULL_RST = 16'sh03E8;
	localparam logic [15:0] MARGIN_RST = 16'h0000;
	localparam logic [31:0] PEAK_RST = 32'h00000000;
	localparam logic [31:0] RELAY_RST = 32'h00000000;

	// input modes
	localparam logic [1:0] MODE_4_20 = 2'h0;
	localparam logic [1:0] MODE_0_20 = 2'h1;
	localparam logic [1:0] MODE_VOLT = 2'h2;
	localparam logic [1:0] MODE_OTHER = 2'h3;

	// input span points, microamps or microvolts, and the percent divisor
	localparam logic signed [31:0] I4_UA = 32'sh00000FA0;
	localparam logic signed [31:0] I20_UA = 32'sh00004E20;
	localparam logic signed [31:0] VOLT_SPAN = 32'sh00002710;
	localparam logic signed [31:0] PCT_DIV = 32'sh00000064;

	// display limits -999 and 9999
	localparam logic signed [31:0] DISP_MIN = 32'shFFFFFC19;
	localparam logic signed [31:0] DISP_MAX = 32'sh0000270F;

	// timing
	localparam int CLK_KHZ = 250000;
	localparam int BOOT_TIME_MS = 3000;
	localparam int BACK_HOLD_MS = 2000;
	localparam int HOLD_TICK_MS = 100;
	localparam int BOOT_CYC = BOOT_TIME_MS * CLK_KHZ;
	localparam int BACK_CYC = BACK_HOLD_MS * CLK_KHZ;
	localparam int TICK_CYC = HOLD_TICK_MS * CLK_KHZ;

	typedef enum logic [2:0] {
		NO_WARNING,
		SENSOR_FAULT_WARNING,
		ABOVE_RANGE_WARNING,
		UNDER_RANGE_WARNING,
		DISPLAY_EXCESS_WARNING
	} mvp_warn_t;

	typedef enum logic [1:0] {SRC_UNIVERSAL, SRC_DIGITAL, SRC_MODBUS, SRC_MATH} mvp_src_t;

	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh00007FFF) begin
			return 16'sh7FFF;
		end else if (v < 32'shFFFF8000) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction

endpackage

/* mvp_scale.sv */
// universal input normalisation, linear scaling and range checks
`timescale 1ns/1ps
`default_nettype none
module mvp_scale
	import mvp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic signed [31:0] raw,
	input wire logic valid,
	input wire logic fault,
	input wire logic [1:0] mode,
	input wire logic signed [15:0] zero_pt,
	input wire logic signed [15:0] full_pt,
	input wire logic [7:0] bot_pct,
	input wire logic [7:0] top_pct,
	output logic signed [15:0] value_q,
	output mvp_warn_t warn_q,
	output logic valid_q
);
	logic signed [31:0] start, stop, lo_b, hi_b, disp;
	logic signed [47:0] norm;
	logic signed [63:0] prod;

	always_comb begin
		start = '0;
		stop = VOLT_SPAN;
		if (mode == MODE_4_20) begin
			start = I4_UA;
			stop = I20_UA;
		end else if (mode == MODE_0_20) begin
			stop = I20_UA;
		end
		lo_b = start;
		hi_b = stop;
		// margins only for current or voltage
		if (mode != MODE_OTHER) begin
			lo_b = start - start * $signed({24'h000000, bot_pct}) / PCT_DIV;
			hi_b = stop + stop * $signed({24'h000000, top_pct}) / PCT_DIV;
		end
		norm = ((48'(raw) - 48'(start)) <<< 16) / 48'(stop - start);
		// linear between zero and full point
		prod = 64'(norm) * (64'(full_pt) - 64'(zero_pt));
		disp = 32'(prod >>> 16) + 32'(zero_pt);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			value_q <= '0;
			warn_q <= NO_WARNING;
			valid_q <= 1'b0;
		end else begin
			valid_q <= valid;
			if (valid) begin
				value_q <= sat16(disp);
				if (fault) begin
					warn_q <= SENSOR_FAULT_WARNING;
				end else if (raw > hi_b) begin
					warn_q <= ABOVE_RANGE_WARNING;
				end else if (raw < lo_b) begin
					warn_q <= UNDER_RANGE_WARNING;
				end else if (disp < DISP_MIN || disp > DISP_MAX) begin
					warn_q <= DISPLAY_EXCESS_WARNING;
				end else begin
					warn_q <= NO_WARNING;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* mvp_peak.sv */
// peak detection with timed or latched hold
`timescale 1ns/1ps
`default_nettype none
module mvp_peak
	import mvp_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic signed [15:0] value,
	input wire logic valid,
	input wire logic [15:0] thr,
	input wire logic [15:0] hold_time,
	input wire logic policy_hold,
	input wire logic clear,
	output logic signed [15:0] peak_q,
	output logic shown_q
);
	logic signed [15:0] ext_q;
	logic rising_q;
	logic [31:0] tick_q;
	logic [15:0] tenths_q;
	logic detect;
	logic signed [16:0] drop, rise;

	if (TICK_CYCLES < 1) begin : g_chk
		$error("mvp_peak: tick count must be at least one");
	end

	always_comb begin
		drop = 17'(ext_q) - 17'(value);
		rise = 17'(value) - 17'(ext_q);
		detect = valid && rising_q && value <= ext_q && drop >= $signed({1'b0, thr});
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ext_q <= '0;
			rising_q <= 1'b1;
		end else if (valid) begin
			if (rising_q) begin
				if (value > ext_q) begin
					ext_q <= value;
				end else if (detect) begin
					ext_q <= value;
					rising_q <= 1'b0;
				end
			end else if (value < ext_q) begin
				ext_q <= value;
			end else if (rise >= $signed({1'b0, thr})) begin
				ext_q <= value;
				rising_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			shown_q <= 1'b0;
			peak_q <= '0;
			tick_q <= '0;
			tenths_q <= '0;
		// real policy with zero time holds nothing
		end else if (detect && (hold_time != 16'h0000 || policy_hold)) begin
			shown_q <= 1'b1;
			peak_q <= ext_q;
			tick_q <= '0;
			tenths_q <= '0;
		end else if (shown_q && hold_time == 16'h0000) begin
			if (clear || !policy_hold) begin
				shown_q <= 1'b0;
			end
		end else if (shown_q) begin
			if (tick_q == 32'(TICK_CYCLES - 1)) begin
				tick_q <= '0;
				tenths_q <= tenths_q + 16'h0001;
			end else begin
				tick_q <= tick_q + 32'h00000001;
			end
			// time out returns to live value
			if (tenths_q >= hold_time) begin
				shown_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* mvp_top.sv */
// meter value processing: sequencing, keys, channels and register slave
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - show identification about three seconds, then enter measurement by itself
// - main menu only after back key held two seconds
// - back key during edit drops the pending value
// - enter key during edit stores the edited value
// - four channels always run; one, two or four visible
// - each channel sources universal, digital, modbus or math value
// - digital sensor values taken continuously without trigger
// - extended margins apply only in current or voltage mode
// - outside permissible range show above or under range warning
// - sensor fault shows sensor fault warning
// - display value outside -999..9999 shows display excess warning; only the universal input value is checked
// - enter shows relay threshold; edits only when relay unlocked
// - measuring continues during any configuration change
// - universal input peak: rise then fall by threshold
// - peak shown for hold time; newer peak restarts timer
// - hold time expiry returns to live value
// - hold policy with zero time latches until back key
// - real policy with zero time holds no peak
// - peak shown indicator while a peak is displayed
// - each output driven from live or peak value
// - normalise: minus 4 over 16 mA, or over 20 mA
// - same formula beyond nominal range, no clamping
// - value is normalised times span plus zero point
// - zero point above full point gives falling scale
module mvp_top
	import mvp_pkg::*;
#(
	parameter int BOOT_CYCLES = BOOT_CYC,
	parameter int BACK_CYCLES = BACK_CYC,
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic signed [31:0] uni_raw,
	input wire logic uni_valid,
	input wire logic uni_fault,
	input wire logic signed [15:0] dig_value,
	input wire logic dig_valid,
	input wire logic dig_fault,
	input wire logic back_key,
	input wire logic enter_key,
	input wire logic up_key,
	input wire logic down_key,
	output logic [2:0] ui_state,
	output logic signed [15:0] edit_value,
	output logic [3:0][15:0] chan_value,
	output logic [3:0][2:0] chan_warn,
	output logic [3:0] chan_peak_shown,
	output logic [3:0][15:0] out_drive,
	output logic [3:0] chan_visible
);
	typedef enum logic [2:0] {ST_BOOT, ST_MEAS, ST_MENU, ST_EDIT, ST_QUICK, ST_QEDIT} mvp_state_t;

	if (BOOT_CYCLES < 1 || BACK_CYCLES < 1 || TICK_CYCLES < 1) begin : g_chk
		$error("mvp_top: cycle counts must be at least one");
	end

	mvp_state_t state_q;
	logic [31:0] boot_cnt_q, back_cnt_q;
	logic back_prev_q, enter_prev_q, up_prev_q, down_prev_q;
	logic back_press, enter_press, up_press, down_press;
	logic [1:0] menu_sel_q;
	logic signed [15:0] edit_q;

	logic [31:0] ctrl_q, peak_cfg_q, relay_q;
	logic [7:0] src_q;
	logic signed [15:0] zero_q, full_q, modbus_q;
	logic [15:0] margin_q;

	logic wr_en;
	logic signed [15:0] uni_val, pk_val, dig_q;
	mvp_warn_t uni_warn;
	logic uni_done, pk_shown;
	mvp_warn_t dig_warn_q;

	assign back_press = back_key & ~back_prev_q;
	assign enter_press = enter_key & ~enter_prev_q;
	assign up_press = up_key & ~up_prev_q;
	assign down_press = down_key & ~down_prev_q;
	assign wr_en = avs_write & ~avs_waitrequest;
	assign ui_state = state_q;
	assign edit_value = edit_q;

	function automatic logic signed [15:0] menu_param(input logic [1:0] sel,
		input logic signed [15:0] z, input logic signed [15:0] f, input logic [31:0] pk);
		case (sel)
			2'h0: return z;
			2'h1: return f;
			2'h2: return pk[15:0];
			default: return pk[31:16];
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (rst) begin
			back_prev_q <= 1'b0;
			enter_prev_q <= 1'b0;
			up_prev_q <= 1'b0;
			down_prev_q <= 1'b0;
		end else begin
			back_prev_q <= back_key;
			enter_prev_q <= enter_key;
			up_prev_q <= up_key;
			down_prev_q <= down_key;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			boot_cnt_q <= '0;
		end else if (state_q == ST_BOOT) begin
			boot_cnt_q <= boot_cnt_q + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !back_key || state_q != ST_MEAS) begin
			back_cnt_q <= '0;
		end else if (back_cnt_q != 32'(BACK_CYCLES - 1)) begin
			back_cnt_q <= back_cnt_q + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_BOOT;
		end else begin
			case (state_q)
				ST_BOOT: begin
					if (boot_cnt_q == 32'(BOOT_CYCLES - 1)) begin
						state_q <= ST_MEAS;
					end
				end
				ST_MEAS: begin
					if (back_key && back_cnt_q == 32'(BACK_CYCLES - 1)) begin
						state_q <= ST_MENU;
					end else if (enter_press) begin
						state_q <= ST_QUICK;
					end
				end
				ST_MENU: begin
					if (enter_press) begin
						state_q <= ST_EDIT;
					end else if (back_press) begin
						state_q <= ST_MEAS;
					end
				end
				ST_EDIT: begin
					if (enter_press || back_press) begin
						state_q <= ST_MENU;
					end
				end
				ST_QUICK: begin
					if (back_press) begin
						state_q <= ST_MEAS;
					end else if (enter_press && ctrl_q[CTRL_UNLOCK]) begin
						state_q <= ST_QEDIT;
					end
				end
				ST_QEDIT: begin
					if (enter_press || back_press) begin
						state_q <= ST_QUICK;
					end
				end
				default: state_q <= ST_MEAS;
			endcase
		end
	end

	// menu selection and edit buffer
	always_ff @(posedge clk) begin
		if (rst) begin
			menu_sel_q <= '0;
			edit_q <= '0;
		end else begin
			case (state_q)
				ST_MENU: begin
					if (up_press) begin
						menu_sel_q <= menu_sel_q + 2'h1;
					end else if (down_press) begin
						menu_sel_q <= menu_sel_q - 2'h1;
					end
					edit_q <= menu_param(menu_sel_q, zero_q, full_q, peak_cfg_q);
				end
				ST_EDIT, ST_QEDIT: begin
					if (up_press) begin
						edit_q <= edit_q + 16'sh0001;
					end else if (down_press) begin
						edit_q <= edit_q - 16'sh0001;
					end
				end
				ST_QUICK: edit_q <= relay_q[15:0];
				default: edit_q <= edit_q;
			endcase
		end
	end

	// configuration: bus writes and key commits; processing never pauses
	// configuration beside running measurement
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			src_q <= SRC_RST;
			zero_q <= ZERO_RST;
			full_q <= FULL_RST;
			margin_q <= MARGIN_RST;
			peak_cfg_q <= PEAK_RST;
			modbus_q <= '0;
			relay_q <= RELAY_RST;
		end else begin
			if (wr_en) begin
				if (avs_address == REG_CTRL) begin
					ctrl_q <= avs_writedata;
				end else if (avs_address == REG_SRC) begin
					src_q <= avs_writedata[7:0];
				end else if (avs_address == REG_ZERO) begin
					zero_q <= avs_writedata[15:0];
				end else if (avs_address == REG_FULL) begin
					full_q <= avs_writedata[15:0];
				end else if (avs_address == REG_MARGIN) begin
					margin_q <= avs_writedata[15:0];
				end else if (avs_address == REG_PEAK) begin
					peak_cfg_q <= avs_writedata;
				end else if (avs_address == REG_MODBUS) begin
					modbus_q <= avs_writedata[15:0];
				end else if (avs_address == REG_RELAY) begin
					relay_q <= avs_writedata;
				end
			end
			if (state_q == ST_EDIT && enter_press) begin
				case (menu_sel_q)
					2'h0: zero_q <= edit_q;
					2'h1: full_q <= edit_q;
					2'h2: peak_cfg_q[15:0] <= edit_q;
					default: peak_cfg_q[31:16] <= edit_q;
				endcase
			end
			if (state_q == ST_QEDIT && enter_press) begin
				relay_q[15:0] <= edit_q;
			end
		end
	end

	// digital sensor sampled on every valid
	always_ff @(posedge clk) begin
		if (rst) begin
			dig_q <= '0;
			dig_warn_q <= NO_WARNING;
		end else if (dig_valid) begin
			dig_q <= dig_value;
			dig_warn_q <= dig_fault ? SENSOR_FAULT_WARNING : NO_WARNING;
		end
	end

	mvp_scale u_scale (
		.clk(clk),
		.rst(rst),
		.raw(uni_raw),
		.valid(uni_valid),
		.fault(uni_fault),
		.mode(ctrl_q[CTRL_MODE_LSB +: 2]),
		.zero_pt(zero_q),
		.full_pt(full_q),
		.bot_pct(margin_q[7:0]),
		.top_pct(margin_q[15:8]),
		.value_q(uni_val),
		.warn_q(uni_warn),
		.valid_q(uni_done)
	);

	// peaks only on the universal input
	mvp_peak #(.TICK_CYCLES(TICK_CYCLES)) u_peak (
		.clk(clk),
		.rst(rst),
		.value(uni_val),
		.valid(uni_done && uni_warn == NO_WARNING),
		.thr(peak_cfg_q[15:0]),
		.hold_time(peak_cfg_q[31:16]),
		.policy_hold(ctrl_q[CTRL_POLICY]),
		.clear(back_press && state_q == ST_MEAS),
		.peak_q(pk_val),
		.shown_q(pk_shown)
	);

	// all four channels run every cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			chan_value <= '0;
			chan_warn <= '0;
			chan_peak_shown <= '0;
			out_drive <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				chan_peak_shown[i] <= 1'b0;
				case (mvp_src_t'(src_q[2*i +: 2]))
					SRC_UNIVERSAL: begin
						chan_value[i] <= pk_shown ? pk_val : uni_val;
						chan_warn[i] <= uni_warn;
						chan_peak_shown[i] <= pk_shown;
						out_drive[i] <= (ctrl_q[CTRL_OUT_PEAK] && pk_shown) ? pk_val : uni_val;
					end
					SRC_DIGITAL: begin
						chan_value[i] <= dig_q;
						chan_warn[i] <= dig_warn_q;
						out_drive[i] <= dig_q;
					end
					SRC_MODBUS: begin
						chan_value[i] <= modbus_q;
						chan_warn[i] <= NO_WARNING;
						out_drive[i] <= modbus_q;
					end
					default: begin
						chan_value[i] <= sat16(32'(uni_val) + 32'(dig_q));
						chan_warn[i] <= (dig_warn_q != NO_WARNING) ? dig_warn_q : uni_warn;
						out_drive[i] <= sat16(32'(uni_val) + 32'(dig_q));
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			chan_visible <= 4'h1;
		end else begin
			case (ctrl_q[CTRL_SHOWN_LSB +: 2])
				2'h0: chan_visible <= 4'h1;
				2'h1: chan_visible <= 4'h3;
				default: chan_visible <= 4'hF;
			endcase
		end
	end

	// bus slave: one wait cycle, then answer
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= '0;
			if (avs_address == REG_CTRL) begin
				avs_readdata <= ctrl_q;
			end else if (avs_address == REG_SRC) begin
				avs_readdata <= {24'h000000, src_q};
			end else if (avs_address == REG_ZERO) begin
				avs_readdata <= {16'h0000, zero_q};
			end else if (avs_address == REG_FULL) begin
				avs_readdata <= {16'h0000, full_q};
			end else if (avs_address == REG_MARGIN) begin
				avs_readdata <= {16'h0000, margin_q};
			end else if (avs_address == REG_PEAK) begin
				avs_readdata <= peak_cfg_q;
			end else if (avs_address == REG_MODBUS) begin
				avs_readdata <= {16'h0000, modbus_q};
			end else if (avs_address == REG_RELAY) begin
				avs_readdata <= relay_q;
			end else if (avs_address == REG_STATUS) begin
				avs_readdata <= {19'h00000, uni_warn, pk_shown, menu_sel_q, 4'h0, state_q};
			end
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* mvp_props.sv */
// checker with bind for the meter value processing top
`timescale 1ns/1ps
`default_nettype none
module mvp_props
	import mvp_pkg::*;
#(
	parameter int BOOT_CYCLES = BOOT_CYC,
	parameter int BACK_CYCLES = BACK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic uni_valid,
	input wire logic uni_fault,
	input wire logic back_key,
	input wire logic [2:0] ui_state,
	input wire logic [3:0][2:0] chan_warn,
	input wire logic [3:0] chan_visible
);
	logic [31:0] boot_q;
	logic [31:0] back_q;
	logic [7:0] src_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk) begin
		boot_q <= (rst || ui_state != 3'h0) ? 32'h0 : boot_q + 32'h1;
		back_q <= (rst || !back_key) ? 32'h0 : back_q + 32'h1;
		src_q <= rst ? SRC_RST : (avs_write && !avs_waitrequest && avs_address == REG_SRC)
			? avs_writedata[7:0] : src_q;
	end
	a_boot_len: assert property (boot_q <= BOOT_CYCLES + 2)
		else $error("boot screen held too long");
	a_boot_early: assert property ($past(ui_state) == 3'h0 && ui_state == 3'h1
		|-> $past(boot_q) >= BOOT_CYCLES - 2) else $error("boot screen left too early");
	a_menu_hold: assert property ($past(ui_state) == 3'h1 && ui_state == 3'h2
		|-> $past(back_q) >= BACK_CYCLES - 2) else $error("menu entered on short press");
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer late");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address == 8'h40
		|=> avs_readdata == 32'h0) else $error("unmapped read not zero");
	a_status_state: assert property (avs_read && avs_waitrequest && avs_address == REG_STATUS
		|=> avs_readdata[2:0] == $past(ui_state)) else $error("status state mismatch");
	a_fault_warn: assert property (uni_valid && uni_fault && src_q[1:0] == 2'h0
		|-> ##2 chan_warn[0] == SENSOR_FAULT_WARNING) else $error("fault warning missing");
	a_visible_mask: assert property (chan_visible inside {4'h1, 4'h3, 4'hF})
		else $error("bad visible mask");
endmodule
bind mvp_top mvp_props #(.BOOT_CYCLES(BOOT_CYCLES), .BACK_CYCLES(BACK_CYCLES)) u_props (
	.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .uni_valid(uni_valid), .uni_fault(uni_fault),
	.back_key(back_key), .ui_state(ui_state), .chan_warn(chan_warn),
	.chan_visible(chan_visible));
`default_nettype wire

/* mvp_front_model.sv */
// sensor front end model: universal samples on request, free running digital sensor
`timescale 1ns/1ps
`default_nettype none
module mvp_front_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic signed [31:0] go_raw,
	input wire logic go_fault,
	input wire logic signed [15:0] dig_level,
	output logic signed [31:0] uni_raw,
	output logic uni_valid,
	output logic uni_fault,
	output logic signed [15:0] dig_value,
	output logic dig_valid,
	output logic dig_fault
);
	logic [3:0] tick_q;
	initial begin
		{uni_raw, uni_valid, uni_fault, dig_value, dig_valid, dig_fault, tick_q} = '0;
	end
	// stale data inverted between samples
	always @(posedge clk) begin
		uni_valid <= go && !rst;
		uni_fault <= go && go_fault;
		uni_raw <= go ? go_raw : ~uni_raw;
	end
	always @(posedge clk) begin
		tick_q <= rst ? 4'h0 : tick_q + 4'h1;
		dig_valid <= tick_q == 4'hF;
		dig_value <= (tick_q == 4'hF) ? dig_level : ~dig_value;
		// negative level stands for a broken sensor
		dig_fault <= (tick_q == 4'hF) && dig_level[15];
	end
endmodule
`default_nettype wire

/* tb_meter_value_processing.sv */
// self-checking bench for the meter value processing block
`timescale 1ns/1ps
`default_nettype none
module tb_meter_value_processing
	import mvp_pkg::*;
;
	logic clk, rst, rd, wr, back, ent, up, dn, go, gof, wrq, uv, uf, dv, df;
	logic [7:0] adr;
	logic [31:0] wd, rdat, rdv;
	logic signed [31:0] graw, uraw;
	logic signed [15:0] dlev, dval, ev;
	logic [2:0] ui;
	logic [3:0][15:0] cval, odrv;
	logic [3:0][2:0] cw;
	logic [3:0] pk, vis;
	int n_fail, compares, lo_b, hi_b, zs, ss;
	mvp_top #(.BOOT_CYCLES(20), .BACK_CYCLES(10), .TICK_CYCLES(4)) uut (.clk(clk), .rst(rst),
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_readdata(rdat), .avs_waitrequest(wrq), .uni_raw(uraw), .uni_valid(uv),
		.uni_fault(uf), .dig_value(dval), .dig_valid(dv), .dig_fault(df), .back_key(back),
		.enter_key(ent), .up_key(up), .down_key(dn), .ui_state(ui), .edit_value(ev),
		.chan_value(cval), .chan_warn(cw), .chan_peak_shown(pk), .out_drive(odrv),
		.chan_visible(vis));
	mvp_front_model u_front (.clk(clk), .rst(rst), .go(go), .go_raw(graw), .go_fault(gof),
		.dig_level(dlev), .uni_raw(uraw), .uni_valid(uv), .uni_fault(uf), .dig_value(dval),
		.dig_valid(dv), .dig_fault(df));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		@(posedge clk);
		while (wrq !== 1'b0 && t < 50) begin
			@(posedge clk);
			t++;
		end
		rdv = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (t == 50) n_fail++;
		@(posedge clk);
	endtask
	task automatic samp(input int raw, input logic f);
		go <= 1'b1;
		graw <= raw;
		gof <= f;
		@(posedge clk);
		go <= 1'b0;
		repeat (5) @(posedge clk);
	endtask
	function automatic logic [2:0] ewarn(input int raw, input logic f, input int w);
		if (f) return 3'h1;
		if (raw > hi_b) return 3'h2;
		if (raw < lo_b) return 3'h3;
		if (w < -999 || w > 9999) return 3'h4;
		return 3'h0;
	endfunction
	task automatic meas(input int k, input logic f);
		int raw, w;
		raw = 4000 + 250 * k;
		w = zs + ss * k;
		samp(raw, f);
		check(cw[0], ewarn(raw, f, w));
		if (ewarn(raw, f, w) == 3'h0) check(cval[0], w & 32'h0000FFFF);
	endtask
	task automatic scl(input int zz, input int sg);
		zs = zz;
		ss = sg;
		bus(1'b1, REG_ZERO, 32'(zz));
		bus(1'b1, REG_FULL, 32'(zz + 64 * sg));
	endtask
	task automatic press(input logic [3:0] keys, input int n);
		{back, ent, up, dn} <= keys;
		repeat (n) @(posedge clk);
		{back, ent, up, dn} <= 4'h0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		summarize();
	end
	initial begin
		int i, k, t;
		logic [3:0] vm [3];
		int zt [3];
		int st [3];
		vm = '{4'h1, 4'h3, 4'hF};
		zt = '{0, 1600, 9980};
		st = '{1, -1, 1};
		{rd, wr, back, ent, up, dn, go, gof, adr, wd, graw, dlev} = '0;
		{n_fail, compares} = '0;
		lo_b = 3200;
		hi_b = 22000;
		rst = 1'b1;
		void'($urandom(32'hA4963C70));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(ui, 3'h0);
		bus(1'b0, REG_SRC, 32'h0);
		check(rdv, 32'h000000E4);
		bus(1'b0, REG_FULL, 32'h0);
		check(rdv[15:0], 16'h03E8);
		t = 0;
		while (ui !== 3'h1 && t < 100) begin
			@(posedge clk);
			t++;
		end
		check(ui, 3'h1);
		bus(1'b0, REG_STATUS, 32'h0);
		check(rdv[2:0], 3'h1);
		bus(1'b1, 8'h40, 32'h5A5A5A5A);
		bus(1'b0, 8'h40, 32'h0);
		check(rdv, 32'h0);
		$display("test boot and bus done");
		bus(1'b1, REG_MARGIN, 32'h00000A14);
		for (i = 0; i < 3; i++) begin
			scl(zt[i], st[i]);
			meas(-4, 1'b0);
			meas(-3, 1'b0);
			meas(72, 1'b0);
			meas(73, 1'b0);
			meas(-4, 1'b1);
			repeat (6) meas(int'($urandom_range(75, 0)) - 3, 1'b0);
		end
		scl(0, 1);
		bus(1'b1, REG_MARGIN, 32'h0);
		lo_b = 4000;
		hi_b = 20000;
		meas(-1, 1'b0);
		meas(1, 1'b0);
		bus(1'b1, REG_CTRL, 32'h00000001);
		samp(12500, 1'b0);
		check(cval[0], 16'd40);
		bus(1'b1, REG_CTRL, 32'h0);
		$display("test scaling done");
		dlev <= 16'($urandom_range(999, 0));
		bus(1'b1, REG_MODBUS, 32'h00000123);
		repeat (40) @(posedge clk);
		check(cval[1], dlev);
		check(cval[2], 16'h0123);
		check(cval[3], 40 + dlev);
		for (i = 0; i < 3; i++) begin
			bus(1'b1, REG_CTRL, 32'(i << 4));
			repeat (3) @(posedge clk);
			check(vis, vm[i]);
		end
		dlev <= 16'shFFFF;
		repeat (40) @(posedge clk);
		check(cw[1], 3'h1);
		$display("test channels done");
		bus(1'b1, REG_MARGIN, 32'h00000A14);
		lo_b = 3200;
		hi_b = 22000;
		bus(1'b1, REG_CTRL, 32'h00000003);
		samp(10500, 1'b0);
		check(cw[0], 3'h2);
		bus(1'b1, REG_CTRL, 32'h00000002);
		samp(10500, 1'b0);
		check(cw[0], 3'h0);
		check(cval[0], 16'd67);
		bus(1'b1, REG_CTRL, 32'h00000040);
		bus(1'b1, REG_PEAK, 32'h00050005);
		samp(6500, 1'b0);
		samp(11500, 1'b0);
		samp(9000, 1'b0);
		check(pk[0], 1'b1);
		check(cval[0], 16'd30);
		samp(15250, 1'b0);
		samp(12750, 1'b0);
		check(cval[0], 16'd45);
		check(odrv[0], 16'd45);
		repeat (14) @(posedge clk);
		check(pk[0], 1'b1);
		t = 0;
		while (pk[0] !== 1'b0 && t < 60) begin
			@(posedge clk);
			t++;
		end
		check(cval[0], 16'd35);
		bus(1'b1, REG_CTRL, 32'h00000004);
		bus(1'b1, REG_PEAK, 32'h00000005);
		samp(6500, 1'b0);
		samp(11500, 1'b0);
		samp(9000, 1'b0);
		repeat (60) @(posedge clk);
		check(pk[0], 1'b1);
		press(4'h8, 2);
		check(pk[0], 1'b0);
		bus(1'b1, REG_CTRL, 32'h0);
		samp(6500, 1'b0);
		samp(11500, 1'b0);
		samp(9000, 1'b0);
		check(pk[0], 1'b0);
		bus(1'b1, REG_PEAK, 32'h0);
		$display("test peaks done");
		press(4'h8, 5);
		check(ui, 3'h1);
		press(4'h8, 14);
		check(ui, 3'h2);
		press(4'h4, 1);
		press(4'h2, 1);
		check(ev, 16'h0001);
		meas(7, 1'b0);
		press(4'h8, 1);
		bus(1'b0, REG_ZERO, 32'h0);
		check(rdv[15:0], 16'h0000);
		press(4'h4, 1);
		press(4'h2, 1);
		press(4'h2, 1);
		press(4'h2, 1);
		press(4'h1, 1);
		press(4'h4, 1);
		bus(1'b0, REG_ZERO, 32'h0);
		check(rdv[15:0], 16'h0002);
		press(4'h2, 1);
		check(ev, 16'h0040);
		press(4'h8, 1);
		check(ui, 3'h1);
		bus(1'b1, REG_RELAY, 32'h00000123);
		press(4'h4, 1);
		check(ev, 16'h0123);
		press(4'h4, 1);
		press(4'h2, 1);
		press(4'h4, 1);
		bus(1'b0, REG_RELAY, 32'h0);
		check(rdv[15:0], 16'h0123);
		press(4'h8, 1);
		bus(1'b1, REG_CTRL, 32'h00000008);
		press(4'h4, 1);
		press(4'h4, 1);
		check(ui, 3'h5);
		press(4'h2, 1);
		press(4'h4, 1);
		bus(1'b0, REG_RELAY, 32'h0);
		check(rdv[15:0], 16'h0124);
		$display("test keys done");
		summarize();
	end
endmodule
`default_nettype wire
